/* File: hw/scs_params.svh */
// Register offsets, field positions, reset values and timing constants of the sensor settings bank.
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH

// ==========================================================================
// Register offsets
`define SCS_OFF_TUNE_MULDIV   8'h28
`define SCS_OFF_TUNE_COMP     8'h29
`define SCS_OFF_PROX_SET      8'h40
`define SCS_OFF_TOUCH_SET     8'h41
`define SCS_OFF_SYS_CTRL      8'h70
`define SCS_OFF_EVT_TIMEOUT   8'h81
`define SCS_OFF_EVT_MASK      8'h82

// ==========================================================================
// Reset values
`define SCS_RST_TUNE_MULDIV   16'h0000
`define SCS_RST_TUNE_COMP     16'h0000
`define SCS_RST_PROX_SET      16'h0000
`define SCS_RST_TOUCH_SET     16'h0000
`define SCS_RST_EVT_TIMEOUT   16'h0000
`define SCS_RST_EVT_MASK      16'h0000
`define SCS_RST_IFACE         2'h0
`define SCS_RST_POWER         2'h0

// ==========================================================================
// System control fields
`define SCS_SYS_IFACE_HI      7
`define SCS_SYS_IFACE_LO      6
`define SCS_SYS_POWER_HI      5
`define SCS_SYS_POWER_LO      4
`define SCS_SYS_TRIG_HI       3
`define SCS_SYS_TRIG_LO       0
`define SCS_TRIG_RESEED       3
`define SCS_TRIG_RETUNE       2
`define SCS_TRIG_SOFT_RESET   1
`define SCS_TRIG_ACK_RESET    0
`define SCS_IFACE_RESERVED    2'h2
`define SCS_POWER_RESERVED    2'h3

// ==========================================================================
// Field positions of the settings and timeout words
`define SCS_PROX_EXIT_HI      15
`define SCS_PROX_EXIT_LO      12
`define SCS_PROX_ENTER_HI     11
`define SCS_PROX_ENTER_LO     8
`define SCS_PROX_THR_HI       7
`define SCS_PROX_THR_LO       0
`define SCS_TOUCH_HYST_HI     15
`define SCS_TOUCH_HYST_LO     8
`define SCS_TOUCH_THR_HI      7
`define SCS_TOUCH_THR_LO      0
`define SCS_TOUCH_TMO_HI      15
`define SCS_TOUCH_TMO_LO      8
`define SCS_PROX_TMO_HI       7
`define SCS_PROX_TMO_LO       0

// ==========================================================================
// Threshold scaling: value times average, divided by 256.
`define SCS_PROX_THR_SHIFT    8

// ==========================================================================
// Timeout step
`define SCS_TIMEOUT_STEP_MS   500
`define SCS_CLK_HZ            40000000
`define SCS_STEP_CYCLES       (`SCS_TIMEOUT_STEP_MS * (`SCS_CLK_HZ / 1000))

`endif

/* File: hw/scs_pkg.sv */
// Types shared by the sensor settings bank.
package scs_pkg;

  // ========================================================================
  // Mode encodings
  typedef enum logic [1:0] {
    SCS_IFACE_STANDALONE = 2'h0,
    SCS_IFACE_STREAMING  = 2'h1,
    SCS_IFACE_RSVD       = 2'h2,
    SCS_IFACE_EVENTS     = 2'h3
  } scs_iface_type;

  typedef enum logic [1:0] {
    SCS_POWER_NORMAL = 2'h0,
    SCS_POWER_ULP    = 2'h1,
    SCS_POWER_AUTO   = 2'h2,
    SCS_POWER_RSVD   = 2'h3
  } scs_power_type;

  // ========================================================================
  // Register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } scs_req_type;

  // ========================================================================
  // Settings seen by the sensing front end
  typedef struct packed {
    logic [3:0]    prox_debounce_exit;
    logic [3:0]    prox_debounce_enter;
    logic [15:0]   prox_threshold;
    logic [7:0]    touch_hysteresis;
    logic [7:0]    touch_threshold;
    scs_iface_type iface;
    scs_power_type power;
    logic [15:0]   tune_muldiv;
    logic [15:0]   tune_comp;
    logic [15:0]   event_mask;
  } scs_cfg_type;

endpackage : scs_pkg

/* File: hw/scs_settings_regs.sv */
// Settings and control register bank of the single-channel sensing controller.
`timescale 1ns/1ps
`include "scs_params.svh"

// Contract
// - Upper nibble of proximity settings is exit debounce; zero disables it.
// - Second nibble of proximity settings is entry debounce; zero disables it.
// - Proximity threshold equals low byte times long-term average over 256.
// - Touch settings hold hysteresis in upper byte, threshold in lower.
// - System control bits 7-6 select standalone, streaming or event interface; 10 reserved.
// - Writing one to bits 3-0 triggers reseed, retune, soft reset, acknowledge.
// - Touch event ends after upper timeout byte times 500 ms.
// - Proximity event ends after lower timeout byte times 500 ms.
// - Dynamic-calibration variants adapt tracking on touch timeout instead of clearing.
module scs_settings_regs #(
  parameter int unsigned STEP_CYCLES = `SCS_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic                i_clk_sys,
  input  wire logic                i_nrst,
  // Register port from the serial target
  input  wire scs_pkg::scs_req_type i_req,
  output logic [15:0]              o_reg_rdata,
  output logic                     o_reg_rvalid,
  // Front-end status
  input  wire logic [15:0]         i_long_term_average,
  input  wire logic                i_touch_active,
  input  wire logic                i_prox_active,
  input  wire logic                i_dynamic_cal,
  input  wire logic [3:0]          i_trigger_taken,
  // Settings and commands to the front end
  output scs_pkg::scs_cfg_type     o_cfg,
  output logic [3:0]               o_trigger_req,
  output logic                     o_touch_clear,
  output logic                     o_touch_adapt,
  output logic                     o_prox_clear
);

  // ========================================================================
  // Storage
  logic [15:0]          tune_muldiv;
  logic [15:0]          tune_comp;
  logic [15:0]          prox_set;
  logic [15:0]          touch_set;
  logic [15:0]          evt_timeout;
  logic [15:0]          evt_mask;
  scs_pkg::scs_iface_type iface;
  scs_pkg::scs_power_type power;
  logic [3:0]           trig;
  logic [24:0]          step_cnt;
  logic                 step_tick;
  logic [7:0]           touch_cnt;
  logic [7:0]           prox_cnt;
  logic                 touch_done;
  logic                 prox_done;

  // ========================================================================
  // Decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  wire logic wr_muldiv  = i_req.wr && hit(i_req.addr, `SCS_OFF_TUNE_MULDIV);
  wire logic wr_comp    = i_req.wr && hit(i_req.addr, `SCS_OFF_TUNE_COMP);
  wire logic wr_prox    = i_req.wr && hit(i_req.addr, `SCS_OFF_PROX_SET);
  wire logic wr_touch   = i_req.wr && hit(i_req.addr, `SCS_OFF_TOUCH_SET);
  wire logic wr_sys     = i_req.wr && hit(i_req.addr, `SCS_OFF_SYS_CTRL);
  wire logic wr_timeout = i_req.wr && hit(i_req.addr, `SCS_OFF_EVT_TIMEOUT);
  wire logic wr_mask    = i_req.wr && hit(i_req.addr, `SCS_OFF_EVT_MASK);

  wire logic [1:0] wr_iface = i_req.wdata[`SCS_SYS_IFACE_HI:`SCS_SYS_IFACE_LO];
  wire logic [1:0] wr_power = i_req.wdata[`SCS_SYS_POWER_HI:`SCS_SYS_POWER_LO];
  wire logic [3:0] wr_trig  = i_req.wdata[`SCS_SYS_TRIG_HI:`SCS_SYS_TRIG_LO];

  wire logic iface_ok = (wr_iface != `SCS_IFACE_RESERVED);
  wire logic power_ok = (wr_power != `SCS_POWER_RESERVED);

  wire logic [15:0] sys_view = {8'h00, iface, power, trig};

  logic [15:0] next_rdata;
  always_comb
  begin
    next_rdata = 16'h0000;
    case (i_req.addr)
      `SCS_OFF_TUNE_MULDIV: next_rdata = tune_muldiv;
      `SCS_OFF_TUNE_COMP:   next_rdata = tune_comp;
      `SCS_OFF_PROX_SET:    next_rdata = prox_set;
      `SCS_OFF_TOUCH_SET:   next_rdata = touch_set;
      `SCS_OFF_SYS_CTRL:    next_rdata = sys_view;
      `SCS_OFF_EVT_TIMEOUT: next_rdata = evt_timeout;
      `SCS_OFF_EVT_MASK:    next_rdata = evt_mask;
      default:              next_rdata = 16'h0000;
    endcase
  end

  // ========================================================================
  // Register writes
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tune_muldiv <= `SCS_RST_TUNE_MULDIV;
      tune_comp   <= `SCS_RST_TUNE_COMP;
      prox_set    <= `SCS_RST_PROX_SET;
      touch_set   <= `SCS_RST_TOUCH_SET;
      evt_timeout <= `SCS_RST_EVT_TIMEOUT;
      evt_mask    <= `SCS_RST_EVT_MASK;
    end
    else
    begin
      if (wr_muldiv)
        tune_muldiv <= i_req.wdata;
      if (wr_comp)
        tune_comp <= i_req.wdata;
      if (wr_prox)
        prox_set <= i_req.wdata;
      if (wr_touch)
        touch_set <= i_req.wdata;
      if (wr_timeout)
        evt_timeout <= i_req.wdata;
      if (wr_mask)
        evt_mask <= i_req.wdata;
    end
  end

  // A reserved mode code leaves the previous mode in place.
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      iface <= scs_pkg::SCS_IFACE_STANDALONE;
      power <= scs_pkg::SCS_POWER_NORMAL;
    end
    else
    begin
      if (wr_sys && iface_ok)
        iface <= scs_pkg::scs_iface_type'(wr_iface);
      if (wr_sys && power_ok)
        power <= scs_pkg::scs_power_type'(wr_power);
    end
  end

  // ========================================================================
  // Trigger bits
  // one-shot triggers
  wire logic [3:0] trig_set = wr_sys ? wr_trig : 4'h0;
  wire logic [3:0] next_trig = trig_set | (trig & ~i_trigger_taken);

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      trig <= 4'h0;
    else
      trig <= next_trig;
  end

  // ========================================================================
  // Half-second step divider
  wire logic step_wrap = (step_cnt == 25'(STEP_CYCLES - 1));

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      step_cnt  <= 25'h0000000;
      step_tick <= 1'b0;
    end
    else
    begin
      step_cnt  <= step_wrap ? 25'h0000000 : step_cnt + 25'h0000001;
      step_tick <= step_wrap;
    end
  end

  // ========================================================================
  // Event timeouts, a zero limit never expires
  wire logic [7:0] touch_limit = evt_timeout[`SCS_TOUCH_TMO_HI:`SCS_TOUCH_TMO_LO];
  wire logic [7:0] prox_limit  = evt_timeout[`SCS_PROX_TMO_HI:`SCS_PROX_TMO_LO];
  wire logic touch_hit = step_tick && (touch_limit != 8'h00) && (touch_cnt == touch_limit - 8'h01);
  wire logic prox_hit  = step_tick && (prox_limit != 8'h00) && (prox_cnt == prox_limit - 8'h01);

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      touch_cnt  <= 8'h00;
      touch_done <= 1'b0;
    end
    else if (!i_touch_active)
    begin
      touch_cnt  <= 8'h00;
      touch_done <= 1'b0;
    end
    else if (step_tick && !touch_done)
    begin
      touch_cnt  <= touch_cnt + 8'h01;
      touch_done <= touch_hit;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      prox_cnt  <= 8'h00;
      prox_done <= 1'b0;
    end
    else if (!i_prox_active)
    begin
      prox_cnt  <= 8'h00;
      prox_done <= 1'b0;
    end
    else if (step_tick && !prox_done)
    begin
      prox_cnt  <= prox_cnt + 8'h01;
      prox_done <= prox_hit;
    end
  end

  wire logic touch_expire = i_touch_active && !touch_done && touch_hit;
  wire logic prox_expire  = i_prox_active && !prox_done && prox_hit;

  // ========================================================================
  // Derived settings
  // proximity threshold scaling
  wire logic [23:0] prox_product = prox_set[`SCS_PROX_THR_HI:`SCS_PROX_THR_LO] * i_long_term_average;

  scs_pkg::scs_cfg_type next_cfg;
  always_comb
  begin
    next_cfg = '0;
    next_cfg.prox_debounce_exit  = prox_set[`SCS_PROX_EXIT_HI:`SCS_PROX_EXIT_LO];
    next_cfg.prox_debounce_enter = prox_set[`SCS_PROX_ENTER_HI:`SCS_PROX_ENTER_LO];
    next_cfg.prox_threshold      = prox_product[`SCS_PROX_THR_SHIFT +: 16];
    next_cfg.touch_hysteresis    = touch_set[`SCS_TOUCH_HYST_HI:`SCS_TOUCH_HYST_LO];
    next_cfg.touch_threshold     = touch_set[`SCS_TOUCH_THR_HI:`SCS_TOUCH_THR_LO];
    next_cfg.iface               = iface;
    next_cfg.power               = power;
    next_cfg.tune_muldiv         = tune_muldiv;
    next_cfg.tune_comp           = tune_comp;
    next_cfg.event_mask          = evt_mask;
  end

  // ========================================================================
  // Output flops
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_reg_rdata   <= 16'h0000;
      o_reg_rvalid  <= 1'b0;
      o_cfg         <= '0;
      o_trigger_req <= 4'h0;
      o_touch_clear <= 1'b0;
      o_touch_adapt <= 1'b0;
      o_prox_clear  <= 1'b0;
    end
    else
    begin
      o_reg_rvalid  <= i_req.rd;
      if (i_req.rd)
        o_reg_rdata <= next_rdata;
      o_cfg         <= next_cfg;
      o_trigger_req <= next_trig;
      o_touch_clear <= touch_expire && !i_dynamic_cal;
      o_touch_adapt <= touch_expire && i_dynamic_cal;
      o_prox_clear  <= prox_expire;
    end
  end

endmodule : scs_settings_regs

/* File: verif/scs_settings_regs_sva.sv */
// Port-level checks of the sensor settings bank.
`timescale 1ns/1ps
module scs_settings_regs_sva #(
  parameter int unsigned STEP_CYCLES = 10
) (
  // Clock, reset and inputs
  input wire logic                 i_clk_sys,
  input wire logic                 i_nrst,
  input wire scs_pkg::scs_req_type i_req,
  input wire logic [15:0]          i_long_term_average,
  input wire logic                 i_touch_active,
  input wire logic                 i_prox_active,
  input wire logic                 i_dynamic_cal,
  input wire logic [3:0]           i_trigger_taken,
  // Outputs of the bank
  input wire logic [15:0]          o_reg_rdata,
  input wire logic                 o_reg_rvalid,
  input wire scs_pkg::scs_cfg_type o_cfg,
  input wire logic [3:0]           o_trigger_req,
  input wire logic                 o_touch_clear,
  input wire logic                 o_touch_adapt,
  input wire logic                 o_prox_clear
);
  default clocking dc @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  wire sys_wr = i_req.wr && (i_req.addr == 8'h70);
  wire prx_wr = i_req.wr && (i_req.addr == 8'h40);
  wire tch_wr = i_req.wr && (i_req.addr == 8'h41);
  chk_read_answer: assert property (i_req.rd |=> o_reg_rvalid)
    else $error("read without answer");
  chk_prox_fields: assert property (prx_wr ##1 !i_req.wr |=>
    o_cfg.prox_debounce_exit == $past(i_req.wdata[15:12], 2) && o_cfg.prox_debounce_enter == $past(i_req.wdata[11:8], 2))
    else $error("debounce fields wrong");
  chk_touch_fields: assert property (tch_wr ##1 !i_req.wr |=>
    o_cfg.touch_hysteresis == $past(i_req.wdata[15:8], 2) && o_cfg.touch_threshold == $past(i_req.wdata[7:0], 2))
    else $error("touch fields wrong");
  chk_iface_select: assert property (sys_wr && i_req.wdata[7:6] != 2'h2 ##1 !i_req.wr |=>
    o_cfg.iface == $past(i_req.wdata[7:6], 2)) else $error("interface field wrong");
  chk_power_select: assert property (sys_wr && i_req.wdata[5:4] != 2'h3 ##1 !i_req.wr |=>
    o_cfg.power == $past(i_req.wdata[5:4], 2)) else $error("power field wrong");
  chk_trigger_set: assert property (sys_wr |=>
    (o_trigger_req & $past(i_req.wdata[3:0])) == $past(i_req.wdata[3:0])) else $error("trigger not set");
  chk_trigger_cause: assert property ((o_trigger_req & ~$past(o_trigger_req)) != 4'h0 |->
    $past(sys_wr)) else $error("trigger set without write");
  chk_trigger_clear: assert property ((i_trigger_taken != 4'h0) && !sys_wr |=>
    (o_trigger_req & $past(i_trigger_taken)) == 4'h0) else $error("trigger not cleared");
  chk_touch_clear: assert property (o_touch_clear |->
    $past(i_touch_active) && !$past(i_dynamic_cal) ##1 !o_touch_clear) else $error("bad touch clear");
  chk_touch_adapt: assert property (o_touch_adapt |->
    $past(i_dynamic_cal) && !o_touch_clear) else $error("bad touch adapt");
  chk_prox_clear: assert property (o_prox_clear |->
    $past(i_prox_active) ##1 !o_prox_clear) else $error("bad prox clear");
endmodule : scs_settings_regs_sva

bind scs_settings_regs scs_settings_regs_sva #(.STEP_CYCLES(STEP_CYCLES)) chk_u (
  .i_clk_sys, .i_nrst, .i_req, .i_long_term_average, .i_touch_active, .i_prox_active,
  .i_dynamic_cal, .i_trigger_taken, .o_reg_rdata, .o_reg_rvalid, .o_cfg, .o_trigger_req,
  .o_touch_clear, .o_touch_adapt, .o_prox_clear
);

/* File: verif/scs_host_model.sv */
// Register host issuing strobe reads and writes to the settings bank.
`timescale 1ns/1ps
module scs_host_model (
  // Clock
  input  wire logic                 i_clk_sys,
  // Register port
  output scs_pkg::scs_req_type      o_req,
  input  wire logic [15:0]          i_rdata,
  input  wire logic                 i_rvalid
);
  initial o_req = '0;
  // writes as given.
  // Tuning words are only written back as debug values; trigger bits are ones only when asked for.
  task automatic wr(input logic [7:0] addr, input logic [15:0] data);
    @(negedge i_clk_sys);
    o_req = '{1'b1, 1'b0, addr, data};
    @(negedge i_clk_sys);
    o_req = '{1'b0, 1'b0, ~addr, ~data};
  endtask : wr
  task automatic rd(input logic [7:0] addr, output logic [15:0] data, output logic ok);
    @(negedge i_clk_sys);
    o_req = '{1'b0, 1'b1, addr, ~o_req.wdata};
    @(negedge i_clk_sys);
    ok = i_rvalid;
    data = i_rdata;
    o_req = '{1'b0, 1'b0, ~addr, ~o_req.wdata};
  endtask : rd
endmodule : scs_host_model

/* File: verif/tb_scs_settings_regs.sv */
// Self-checking testbench of the sensor settings bank.
`timescale 1ns/1ps
module tb_scs_settings_regs;
  localparam int unsigned STEP = 10;
  logic                 i_clk_sys;
  logic                 i_nrst;
  scs_pkg::scs_req_type req;
  scs_pkg::scs_cfg_type cfg;
  logic [15:0]          rdata;
  logic [15:0]          long_term_average;
  logic                 rvalid;
  logic                 touch_act;
  logic                 prox_act;
  logic                 dyn_cal;
  logic [3:0]           taken;
  logic [3:0]           trig;
  wire logic [2:0]      pulses;
  int                   err_count;
  int                   samples_checked;

  scs_host_model host_u (.i_clk_sys(i_clk_sys), .o_req(req), .i_rdata(rdata), .i_rvalid(rvalid));
  scs_settings_regs #(.STEP_CYCLES(STEP)) dut_u (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_req(req), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_long_term_average(long_term_average), .i_touch_active(touch_act), .i_prox_active(prox_act),
    .i_dynamic_cal(dyn_cal), .i_trigger_taken(taken), .o_cfg(cfg), .o_trigger_req(trig),
    .o_touch_clear(pulses[1]), .o_touch_adapt(pulses[2]), .o_prox_clear(pulses[0])
  );

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    host_u.rd(a, d, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(d, exp);
  endtask : rdchk
  task automatic t_reset();
    logic [7:0] offs [8] = '{8'h28, 8'h29, 8'h40, 8'h41, 8'h70, 8'h81, 8'h82, 8'h30};
    foreach (offs[i]) rdchk(offs[i], 16'h0000);
  endtask : t_reset
  task automatic t_prox(input logic [15:0] d, input logic [15:0] a);
    long_term_average = a;
    host_u.wr(8'h40, d);
    repeat (2) @(negedge i_clk_sys);
    chk(16'(cfg.prox_debounce_exit), 16'(d[15:12]));
    chk(16'(cfg.prox_debounce_enter), 16'(d[11:8]));
    chk(cfg.prox_threshold, 16'((32'(d[7:0]) * 32'(a)) >> 8));
  endtask : t_prox
  task automatic t_touch();
    host_u.wr(8'h41, 16'hA55A);
    host_u.wr(8'h28, 16'h1357);
    host_u.wr(8'h29, 16'h9BDF);
    host_u.wr(8'h82, 16'h00C3);
    host_u.wr(8'h30, 16'hFFFF);
    rdchk(8'h41, 16'hA55A);
    chk(16'(cfg.touch_hysteresis), 16'h00A5);
    chk(16'(cfg.touch_threshold), 16'h005A);
    rdchk(8'h28, 16'h1357);
    rdchk(8'h29, 16'h9BDF);
    chk(cfg.tune_muldiv, 16'h1357);
    chk(cfg.tune_comp, 16'h9BDF);
    chk(cfg.event_mask, 16'h00C3);
    rdchk(8'h30, 16'h0000);
  endtask : t_touch
  task automatic t_sysctl();
    logic [1:0] ifc;
    logic [1:0] pwr;
    ifc = 2'h0;
    pwr = 2'h0;
    for (int c = 0; c < 4; c++)
    begin
      host_u.wr(8'h70, 16'hFF00 | 16'(c << 6) | 16'(c << 4));
      ifc = (c == 2) ? ifc : 2'(c);
      pwr = (c == 3) ? pwr : 2'(c);
      rdchk(8'h70, {8'h00, ifc, pwr, 4'h0});
      chk(16'(cfg.iface), 16'(ifc));
      chk(16'(cfg.power), 16'(pwr));
    end
  endtask : t_sysctl
  task automatic t_trig();
    for (int n = 0; n < 4; n++)
    begin
      host_u.wr(8'h70, 16'(1 << n));
      chk(16'(trig), 16'(1 << n));
      host_u.wr(8'h70, 16'h0000);
      rdchk(8'h70, 16'(1 << n));
      @(negedge i_clk_sys) taken = 4'(1 << n);
      @(negedge i_clk_sys) taken = 4'h0;
      chk(16'(trig), 16'h0000);
      rdchk(8'h70, 16'h0000);
    end
  endtask : t_trig
  task automatic wait_pulse(input int sel, input int lo, input int hi);
    int n;
    n = 0;
    while (pulses[sel] !== 1'b1 && n <= hi)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    chk(16'(n >= lo && n <= hi), 16'h0001);
    if (n > hi)
      summarize();
  endtask : wait_pulse
  task automatic t_timeout();
    host_u.wr(8'h81, 16'h0302);
    prox_act = 1'b1;
    wait_pulse(0, STEP, 2 * STEP + 2);
    prox_act = 1'b0;
    touch_act = 1'b1;
    wait_pulse(1, 2 * STEP, 3 * STEP + 2);
    @(negedge i_clk_sys) touch_act = 1'b0;
    dyn_cal = 1'b1;
    @(negedge i_clk_sys) touch_act = 1'b1;
    wait_pulse(2, 2 * STEP, 3 * STEP + 2);
    chk(16'(pulses[1]), 16'h0000);
  endtask : t_timeout

  initial
  begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  initial
  begin
    i_nrst = 1'b0;
    long_term_average = 16'h0000;
    touch_act = 1'b0;
    prox_act = 1'b0;
    dyn_cal = 1'b0;
    taken = 4'h0;
    err_count = 0;
    samples_checked = 0;
    repeat (20) @(negedge i_clk_sys);
    i_nrst = 1'b1;
    t_reset();
    t_prox(16'h3264, 16'h1234);
    t_prox(16'hF0FF, 16'hFFFF);
    t_touch();
    t_sysctl();
    t_trig();
    t_timeout();
    summarize();
  end
endmodule : tb_scs_settings_regs
